// ---- hdl/msp_top.sv ----
// module status, start-up straps, reset, power modes and gpio control
`timescale 1ns/1ps
module msp_top
  import msp_pkg::*;
#(
  parameter longint unsigned FACTORY_HOLD = FACTORY_HOLD_CYC,
  parameter int unsigned     STBY_DIV     = STBY_DIV_CYC,
  parameter int unsigned     BLINK        = BLINK_CYC,
  parameter int unsigned     NG           = GPIO_N
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // axi4-lite slave
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  // pins
  input  wire logic          switch_1_n,
  input  wire logic          switch_2_n,
  input  wire logic          dsr_n,
  output logic               dtr_n,
  output msp_led_t           led,
  // events from the rest of the module
  input  wire logic          serial_port_emulation_activity,
  input  wire logic          brownout,
  input  wire msp_wake_t     wake_src,
  // gpio pins, oe low while driven
  input  wire logic [NG-1:0] gpio_in,
  output logic [NG-1:0]      gpio_out,
  output logic [NG-1:0]      gpio_oe_n,
  output logic [NG-1:0]      gpio_high_drive,
  // power status
  output logic               soft_reset,
  output logic               nvm_save_req,
  output logic               standby_clk_en,
  output logic               core_powered,
  output logic               reboot_req,
  output logic               connect_req,
  output logic               serial_lines_en,
  output msp_start_t         start_action,
  output logic               factory_reset
);

  // synchronisers
  logic [1:0] s1_q, s2_q, dsr_q;
  logic [NG-1:0] gs1_q, gs2_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q  <= 2'h3;
      s2_q  <= 2'h3;
      dsr_q <= 2'h3;
      gs1_q <= '0;
      gs2_q <= '0;
    end else begin
      s1_q  <= {s1_q[0], switch_1_n};
      s2_q  <= {s2_q[0], switch_2_n};
      dsr_q <= {dsr_q[0], dsr_n};
      gs1_q <= gpio_in;
      gs2_q <= gs1_q;
    end
  end
  wire sw1_low = ~s1_q[1];
  wire sw2_low = ~s2_q[1];
  wire dsr_low = ~dsr_q[1];

  // registers
  logic [31:0]   ctrl_q, wake_en_q;
  logic [NG-1:0] dir_q, out_q, drv_q, edg_q, evt_q, ena_q, latch_q, gprev_q;
  msp_pwr_t      pwr_q;
  wire           dsr_fall;

  // axi4-lite handshake
  logic       aw_q, w_q, ar_q;
  logic [7:0] awa_q, ara_q;
  logic [31:0] wd_q;
  logic [3:0]  ws_q;
  assign s_axi_awready = ~aw_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_q & ~s_axi_bvalid;
  assign s_axi_arready = ~ar_q & ~s_axi_rvalid;
  wire   wr_go = aw_q & w_q & ~s_axi_bvalid;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= REG_GPIO_ENA);
  endfunction : mapped

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : o[i*8 +: 8];
    end
  endfunction : merge

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_q  <= 1'b0;
      w_q   <= 1'b0;
      awa_q <= 8'h00;
      wd_q  <= 32'h0000_0000;
      ws_q  <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q  <= 1'b1;
        awa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q  <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q  <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awa_q) ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  wire wr_ctrl = wr_go && awa_q == REG_CTRL;
  wire wr_evt  = wr_go && awa_q == REG_GPIO_EVT;

  // registers written by software; standby and sleep bits self-clear when taken, power-off bit once the save is done
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q    <= REG_RESET;
      wake_en_q <= REG_RESET;
      dir_q     <= '0;
      out_q     <= '0;
      drv_q     <= '0;
      edg_q     <= '0;
      ena_q     <= '0;
    end else begin
      if (wr_go) begin
        case (awa_q)
          REG_CTRL:     ctrl_q    <= merge(ctrl_q, wd_q, ws_q);
          REG_WAKE_EN:  wake_en_q <= merge(wake_en_q, wd_q, ws_q);
          REG_GPIO_DIR: dir_q <= NG'(merge(32'(dir_q), wd_q, ws_q));
          REG_GPIO_OUT: out_q <= NG'(merge(32'(out_q), wd_q, ws_q));
          REG_GPIO_DRV: drv_q <= NG'(merge(32'(drv_q), wd_q, ws_q));
          REG_GPIO_EDG: edg_q <= NG'(merge(32'(edg_q), wd_q, ws_q));
          REG_GPIO_ENA: ena_q <= NG'(merge(32'(ena_q), wd_q, ws_q));
          default: ;
        endcase
      end
      if (pwr_q == MSP_ST_SAVING && ctrl_q[CTRL_SAVE_DONE_BIT]) begin
        ctrl_q[CTRL_PWROFF_BIT]    <= 1'b0;
        ctrl_q[CTRL_SAVE_DONE_BIT] <= 1'b0;
      end
      if (pwr_q != MSP_ST_ACTIVE) begin
        ctrl_q[CTRL_STANDBY_BIT] <= 1'b0;
        ctrl_q[CTRL_SLEEP_BIT]   <= 1'b0;
      end
      if (dsr_fall) begin
        ctrl_q[CTRL_CMD_MODE_BIT] <= 1'b1;
        ctrl_q[CTRL_CONNECTED_BIT] <= 1'b0;
        ctrl_q[CTRL_CONNECTING_BIT] <= 1'b0;
      end
    end
  end

  // gpio: disabled pins neither drive nor sense
  wire [NG-1:0] gin = gs2_q & ena_q & ~dir_q;
  assign gpio_oe_n       = ~(ena_q & dir_q);
  assign gpio_out        = out_q;
  assign gpio_high_drive = drv_q;

  // edge flags: set wins over write-one-to-clear
  wire [NG-1:0] rise = gin & ~gprev_q;
  wire [NG-1:0] fall = ~gin & gprev_q;
  wire [NG-1:0] hit  = (edg_q & rise) | (~edg_q & fall);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gprev_q <= '0;
      evt_q   <= '0;
    end else begin
      gprev_q <= gin;
      evt_q   <= (evt_q & ~(wr_evt ? NG'(wd_q) : '0)) | hit;
    end
  end

  // dsr edge and the chosen sleep-control gpio
  logic dsr_prev_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) dsr_prev_q <= 1'b0;
    else        dsr_prev_q <= dsr_low;
  end
  assign dsr_fall = dsr_low & ~dsr_prev_q;
  wire [4:0] sp = ctrl_q[CTRL_SLEEP_PIN_LSB +: 5];
  wire sleep_pin_evt = (sp < 5'(NG)) ? hit[sp] : 1'b0;
  assign serial_lines_en = ~dsr_low;

  // start-up straps, caught once after reset release
  // wait two edges so the synchronisers hold the pin, not their reset value
  logic      started_q;
  logic [1:0]  warm_q;
  logic [63:0] hold_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      started_q     <= 1'b0;
      warm_q        <= 2'h0;
      start_action  <= MSP_START_NORMAL;
      hold_q        <= 64'h0;
      factory_reset <= 1'b0;
    end else begin
      if (!started_q && warm_q != 2'h2) begin
        warm_q <= warm_q + 2'h1;
      end else if (!started_q) begin
        started_q <= 1'b1;
        if (sw1_low && sw2_low)
          start_action <= MSP_START_BOOTLOADER;
        else if (sw2_low)
          start_action <= MSP_START_SERIAL_DEFAULTS;
        else
          start_action <= MSP_START_NORMAL;
      end else if (start_action == MSP_START_BOOTLOADER && !factory_reset) begin
        if (!(sw1_low && sw2_low)) begin
          hold_q <= 64'h0;  // released early: stays in bootloader
        end else if (hold_q >= FACTORY_HOLD - 64'h1) begin
          factory_reset <= 1'b1;
          start_action  <= MSP_START_NORMAL;
        end else begin
          hold_q <= hold_q + 64'h1;
        end
      end
    end
  end
  // strap 2 is a connect request only once start-up is done
  assign connect_req = started_q & sw2_low &
                       (start_action != MSP_START_BOOTLOADER);

  // power state machine; hardware reset arrives on rst_n and skips the save
  logic [12:0] div_q;
  logic [NG-1:0] wake_latch_q;
  wire latch_chg = ctrl_q[CTRL_LATCH_BIT] & |((gs2_q & ena_q) ^ latch_q);
  wire stby_wake = (wake_src.rtc & wake_en_q[WK_RTC]) |
                   (wake_src.radio & wake_en_q[WK_RADIO]) |
                   (wake_src.near_field_detect & wake_en_q[WK_NFD]) |
                   ((wake_src.sensor | |hit) & wake_en_q[WK_SENSOR]);
  // sleep wake ignores rtc and radio by design
  wire slp_wake = ((|hit | latch_chg | sleep_pin_evt) & wake_en_q[WK_PIN]) |
                  (wake_src.lp_comp & wake_en_q[WK_LPCOMP]) |
                  (wake_src.near_field_detect & wake_en_q[WK_NFD]) |
                  latch_chg | sleep_pin_evt;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_q        <= MSP_ST_ACTIVE;
      soft_reset   <= 1'b0;
      reboot_req   <= 1'b0;
      latch_q      <= '0;
    end else begin
      soft_reset <= 1'b0;
      reboot_req <= 1'b0;
      if (brownout) begin
        pwr_q <= MSP_ST_BROWNOUT;
      end else begin
        case (pwr_q)
          MSP_ST_ACTIVE: begin
            if (ctrl_q[CTRL_PWROFF_BIT]) pwr_q <= MSP_ST_SAVING;
            else if (ctrl_q[CTRL_SLEEP_BIT] || sleep_pin_evt || (dsr_fall &&
                     ctrl_q[CTRL_CMD_MODE_BIT])) begin
              pwr_q   <= MSP_ST_SLEEP;
              latch_q <= gs2_q & ena_q;
            end else if (ctrl_q[CTRL_STANDBY_BIT]) pwr_q <= MSP_ST_STANDBY;
          end
          MSP_ST_SAVING: if (ctrl_q[CTRL_SAVE_DONE_BIT]) begin
            soft_reset <= 1'b1;
            pwr_q      <= MSP_ST_ACTIVE;
          end
          MSP_ST_STANDBY: if (stby_wake) pwr_q <= MSP_ST_ACTIVE;
          MSP_ST_SLEEP: if (slp_wake) begin
            reboot_req <= 1'b1;
            pwr_q      <= MSP_ST_ACTIVE;
          end
          MSP_ST_BROWNOUT: ;
          default: pwr_q <= MSP_ST_ACTIVE;
        endcase
      end
    end
  end
  // no save request is made on brown-out or hardware reset
  assign nvm_save_req = (pwr_q == MSP_ST_SAVING);
  assign core_powered = (pwr_q == MSP_ST_ACTIVE) || (pwr_q == MSP_ST_SAVING);

  // standby tick divider, about 32.768 khz from the core clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q          <= 13'h0;
      standby_clk_en <= 1'b0;
    end else begin
      standby_clk_en <= 1'b0;
      if (pwr_q == MSP_ST_STANDBY) begin
        if (div_q >= 13'(STBY_DIV - 1)) begin
          div_q          <= 13'h0;
          standby_clk_en <= 1'b1;
        end else begin
          div_q <= div_q + 13'h1;
        end
      end else begin
        div_q <= 13'h0;
      end
    end
  end

  // status led with activity blink
  logic [31:0] blink_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) blink_q <= 32'h0;
    else if (serial_port_emulation_activity && ctrl_q[CTRL_CONNECTED_BIT])
      blink_q <= 32'(BLINK);
    else if (blink_q != 32'h0) blink_q <= blink_q - 32'h1;
  end
  wire blink_off = (blink_q != 32'h0) && (blink_q < 32'(BLINK / 2));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      led <= '{red_n: 1'b1, green_n: 1'b1, blue_n: 1'b1};
    end else if (!core_powered) begin
      led <= '{red_n: 1'b1, green_n: 1'b1, blue_n: 1'b1};
    end else if (ctrl_q[CTRL_CONNECTED_BIT]) begin
      led <= '{red_n: 1'b1, green_n: 1'b1, blue_n: blink_off};
    end else if (ctrl_q[CTRL_CONNECTING_BIT]) begin
      led <= '{red_n: 1'b0, green_n: 1'b1, blue_n: 1'b0};
    end else if (ctrl_q[CTRL_CMD_MODE_BIT]) begin
      led <= '{red_n: 1'b0, green_n: 1'b0, blue_n: 1'b1};
    end else begin
      led <= '{red_n: 1'b1, green_n: 1'b0, blue_n: 1'b1};
    end
  end

  // dtr indication, active low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) dtr_n <= 1'b1;
    else case (ctrl_q[CTRL_DTR_SEL_LSB +: 2])
      2'h0: dtr_n <= ~ctrl_q[CTRL_CMD_MODE_BIT];
      2'h1: dtr_n <= ~ctrl_q[CTRL_CONNECTED_BIT];
      2'h2: dtr_n <= ~ctrl_q[CTRL_BONDED_BIT];
      default: dtr_n <= ~ctrl_q[CTRL_GAP_BIT];
    endcase
  end

  // read channel, one cycle after the address is taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ar_q  <= 1'b0;
      ara_q <= 8'h00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      ar_q  <= 1'b1;
      ara_q <= s_axi_araddr;
    end else begin
      ar_q <= 1'b0;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= AXI_OKAY;
    end else if (ar_q) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= mapped(ara_q) ? AXI_OKAY : AXI_SLVERR;
      case (ara_q)
        REG_CTRL:     s_axi_rdata <= ctrl_q;
        REG_STATUS:   s_axi_rdata <= {20'h0, factory_reset, 2'(start_action), started_q,
                                      sw2_low, sw1_low, dsr_low, 4'(pwr_q), core_powered};
        REG_WAKE_EN:  s_axi_rdata <= wake_en_q;
        REG_GPIO_DIR: s_axi_rdata <= 32'(dir_q);
        REG_GPIO_OUT: s_axi_rdata <= 32'(out_q);
        REG_GPIO_DRV: s_axi_rdata <= 32'(drv_q);
        REG_GPIO_EDG: s_axi_rdata <= 32'(edg_q);
        REG_GPIO_EVT: s_axi_rdata <= 32'(evt_q);
        REG_GPIO_IN:  s_axi_rdata <= 32'(gin);
        REG_GPIO_ENA: s_axi_rdata <= 32'(ena_q);
        default:      s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  logic unused_ok;
  assign unused_ok = ^{evt_q, wake_latch_q, ara_q};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) wake_latch_q <= '0;
    else        wake_latch_q <= latch_q;
  end

endmodule : msp_top

// ---- hdl/msp_pkg.sv ----
// package for the module status and power control block
package msp_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ            = 250_000_000;
  localparam int unsigned FACTORY_HOLD_S    = 10;
  localparam longint unsigned FACTORY_HOLD_CYC = longint'(FACTORY_HOLD_S) * CLK_HZ;
  localparam int unsigned STBY_CLK_HZ_X1000 = 32_768_000;
  localparam int unsigned STBY_DIV_CYC      = 7629;
  localparam int unsigned BLINK_MS          = 50;
  localparam int unsigned BLINK_CYC         = BLINK_MS * (CLK_HZ / 1000);
  localparam int unsigned GPIO_N            = 19;

  // register byte offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_WAKE_EN  = 8'h08;
  localparam logic [7:0] REG_GPIO_DIR = 8'h0c;
  localparam logic [7:0] REG_GPIO_OUT = 8'h10;
  localparam logic [7:0] REG_GPIO_DRV = 8'h14;
  localparam logic [7:0] REG_GPIO_EDG = 8'h18;
  localparam logic [7:0] REG_GPIO_EVT = 8'h1c;
  localparam logic [7:0] REG_GPIO_IN  = 8'h20;
  localparam logic [7:0] REG_GPIO_ENA = 8'h24;

  // ctrl fields
  localparam int unsigned CTRL_CMD_MODE_BIT  = 0;
  localparam int unsigned CTRL_CONNECTING_BIT = 1;
  localparam int unsigned CTRL_CONNECTED_BIT = 2;
  localparam int unsigned CTRL_PWROFF_BIT    = 3;
  localparam int unsigned CTRL_STANDBY_BIT   = 4;
  localparam int unsigned CTRL_SLEEP_BIT     = 5;
  localparam int unsigned CTRL_LATCH_BIT     = 6;
  localparam int unsigned CTRL_SAVE_DONE_BIT = 7;
  localparam int unsigned CTRL_SLEEP_PIN_LSB = 8;
  localparam int unsigned CTRL_DTR_SEL_LSB   = 16;
  localparam int unsigned CTRL_BONDED_BIT    = 18;
  localparam int unsigned CTRL_GAP_BIT       = 19;

  // wake enable fields
  localparam int unsigned WK_RTC = 0;
  localparam int unsigned WK_RADIO = 1;
  localparam int unsigned WK_NFD = 2;
  localparam int unsigned WK_SENSOR = 3;
  localparam int unsigned WK_PIN = 4;
  localparam int unsigned WK_LPCOMP = 5;

  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [1:0]  AXI_OKAY  = 2'h0;
  localparam logic [1:0]  AXI_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MSP_START_NORMAL,
    MSP_START_SERIAL_DEFAULTS,
    MSP_START_BOOTLOADER
  } msp_start_t;

  typedef enum {
    MSP_ST_ACTIVE,
    MSP_ST_SAVING,
    MSP_ST_STANDBY,
    MSP_ST_SLEEP,
    MSP_ST_BROWNOUT
  } msp_pwr_t;

  typedef struct packed {
    logic red_n;
    logic green_n;
    logic blue_n;
  } msp_led_t;

  typedef struct packed {
    logic rtc;
    logic radio;
    logic near_field_detect;
    logic sensor;
    logic lp_comp;
  } msp_wake_t;

endpackage : msp_pkg

// ---- verif/msp_sva.sv ----
// checker for the status and power control ports
`timescale 1ns/1ps
module msp_sva
  import msp_pkg::*;
#(
  parameter int unsigned NG = GPIO_N
) (
  // clock and reset
  input wire logic          clk,
  input wire logic          rst_n,
  // pins
  input wire logic          dsr_n,
  input wire msp_led_t      led,
  input wire logic          brownout,
  input wire logic [NG-1:0] gpio_oe_n,
  input wire logic [NG-1:0] gpio_high_drive,
  // status
  input wire logic          soft_reset,
  input wire logic          nvm_save_req,
  input wire logic          reboot_req,
  input wire logic          serial_lines_en,
  input wire msp_start_t    start_action,
  input wire logic          factory_reset
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_led_legal: assert property (led inside {3'h5, 3'h1, 3'h2, 3'h6, 3'h7})
    else $error("undefined led code");
  a_save_first: assert property (
    $rose(soft_reset) |-> $past(nvm_save_req) || $past(nvm_save_req, 2))
    else $error("soft reset without save");
  a_soft_pulse: assert property (soft_reset |=> !soft_reset)
    else $error("soft reset too long");
  a_brown_nosave: assert property (brownout |-> ##2 !nvm_save_req && !soft_reset)
    else $error("save after brown-out");
  // led is registered from the state, hence the extra cycle
  a_brown_dark: assert property (brownout |-> ##3 led == 3'h7)
    else $error("led lit after brown-out");
  a_reboot_pulse: assert property (reboot_req |=> !reboot_req)
    else $error("reboot request too long");
  a_factory_sticky: assert property (factory_reset |=> factory_reset)
    else $error("factory flag dropped");
  a_factory_normal: assert property (
    $rose(factory_reset) |-> ##[0:1] start_action == MSP_START_NORMAL)
    else $error("factory left bootloader set");
  a_dsr_gates: assert property ((!dsr_n) [*5] |-> !serial_lines_en)
    else $error("serial lines not gated");
  a_gpio_off: assert property ($rose(rst_n) |-> &gpio_oe_n)
    else $error("gpio driven after reset");
  a_drive_low: assert property ($rose(rst_n) |-> gpio_high_drive == '0)
    else $error("high drive after reset");
endmodule : msp_sva

bind msp_top msp_sva #(.NG(NG)) u_sva (.*);

// ---- verif/msp_host_model.sv ----
// host model: reset, strap and dsr pins with pull-ups
`timescale 1ns/1ps
module msp_host_model (
  // clock and bench requests, high pulls a pin low
  input  wire logic clk,
  input  wire logic rst_req,
  input  wire logic sw1_req,
  input  wire logic sw2_req,
  input  wire logic dsr_req,
  // pins, a released pin sits high on its pull-up
  output logic      rst_n = 1'h0,
  output logic      switch_1_n = 1'h1,
  output logic      switch_2_n = 1'h1,
  output logic      dsr_n = 1'h1
);
  always @(posedge clk) begin
    rst_n      <= !rst_req;
    switch_1_n <= !sw1_req;
    switch_2_n <= !sw2_req;
    dsr_n      <= !dsr_req;
  end
endmodule : msp_host_model

// ---- verif/test_module_status_power_control.sv ----
// self-checking bench for the status and power control block
`timescale 1ns/1ps
module test_module_status_power_control;
  import msp_pkg::*;
  // clock, reset and pin requests
  logic              clk = 1'h0;
  wire logic         rst_n, switch_1_n, switch_2_n, dsr_n;
  logic              rst_req = 1'h1, sw1_req = 1'h0, sw2_req = 1'h0, dsr_req = 1'h0;
  // bus
  logic [7:0]        s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]       s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]        s_axi_wstrb = 4'hf;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic              s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic              s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  // design pins and events
  logic              serial_port_emulation_activity = 1'h0, brownout = 1'h0;
  msp_wake_t         wake_src = '0;
  logic [GPIO_N-1:0] gpio_in = '0, gpio_out, gpio_oe_n, gpio_high_drive;
  msp_led_t          led;
  msp_start_t        start_action;
  logic              dtr_n, soft_reset, nvm_save_req, standby_clk_en, core_powered;
  logic              reboot_req, connect_req, serial_lines_en, factory_reset;
  // bench state
  int                err_count = 0, cmp_count = 0, n_sr, n_rb, n_sc, n_blu;
  logic [31:0]       rd_q, v, w;
  logic [1:0]        rsp;

  always #2 clk = ~clk;

  // short counts keep the long timers inside a short run
  msp_top #(.FACTORY_HOLD(100), .BLINK(20), .STBY_DIV(4)) dut (.*);
  msp_host_model u_host (.*);

  // pulses counted mid-cycle, away from the launching edge
  always @(negedge clk) begin
    n_sr  += int'(soft_reset === 1'h1);
    n_rb  += int'(reboot_req === 1'h1);
    n_sc  += int'(standby_clk_en === 1'h1);
    n_blu += int'(led.blue_n === 1'h1);
  end

  function automatic logic [2:0] led_exp(input logic [2:0] c);
    if (c[2]) return 3'h6;
    if (c[1]) return 3'h2;
    if (c[0]) return 3'h1;
    return 3'h5;
  endfunction : led_exp

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic fin(input string s);
    $display("test %s done", s);
  endtask : fin

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    n = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1 && n < 50);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
    if (n >= 50) chk(0, 1, "no write answer");
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge clk);
    n = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1 && n < 50);
    rd_q = s_axi_rdata;
    s_axi_rready <= 1'h0;
    if (n >= 50) chk(0, 1, "no read answer");
  endtask : rd

  task automatic boot(input logic s1, input logic s2);
    @(posedge clk);
    rst_req <= 1'h1;
    sw1_req <= s1;
    sw2_req <= s2;
    cyc(8);
    rst_req <= 1'h0;
    cyc(6);
  endtask : boot

  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  initial begin
    #40000;
    err_count++;
    close_out();
  end

  initial begin
    v = $urandom(39);
    boot(1'h0, 1'h0);
    chk(start_action, MSP_START_NORMAL, "start");
    chk(gpio_oe_n, 32'h7ffff, "oe reset");
    chk(gpio_high_drive, 0, "drive reset");
    rd(REG_CTRL);
    chk(rd_q, REG_RESET, "ctrl reset");
    wr(8'h40, 0);
    chk(rsp, AXI_SLVERR, "unmapped");
    // sleep-control index 31 keeps gpio traffic from toggling sleep
    for (int i = 0; i < 8; i++) begin
      wr(REG_CTRL, 32'h1f00 | i);
      cyc(3);
      chk(led, led_exp(i[2:0]), "led");
    end
    wr(REG_CTRL, 32'h1f04);
    n_blu = 0;
    serial_port_emulation_activity <= 1'h1;
    cyc(1);
    serial_port_emulation_activity <= 1'h0;
    cyc(30);
    chk(n_blu >= 9 && n_blu <= 11, 1, "blink");
    chk(led, 3'h6, "steady");
    dsr_req <= 1'h1;
    cyc(8);
    chk(serial_lines_en, 0, "gate");
    chk(led, 3'h1, "cmd");
    dsr_req <= 1'h0;
    cyc(8);
    chk(serial_lines_en, 1, "ungate");
    fin("status");
    n_sr = 0;
    wr(REG_CTRL, 32'h1f08);
    for (int i = 0; i < 20 && nvm_save_req !== 1'h1; i++) cyc(1);
    chk(nvm_save_req, 1, "save");
    chk(n_sr, 0, "early reset");
    wr(REG_CTRL, 32'h1f80);
    cyc(4);
    chk(n_sr, 1, "soft reset");
    chk(nvm_save_req, 0, "save end");
    fin("power off");
    v = $urandom_range(32'h7ffff);
    w = $urandom_range(32'h7ffff);
    wr(REG_GPIO_ENA, v);
    wr(REG_GPIO_DIR, w);
    wr(REG_GPIO_DRV, w);
    cyc(2);
    chk(gpio_oe_n, ~(v & w) & 32'h7ffff, "oe");
    chk(gpio_high_drive, w, "drive");
    wr(REG_GPIO_ENA, 32'h7ffff);
    wr(REG_GPIO_DIR, 0);
    wr(REG_GPIO_EDG, v);
    wr(REG_GPIO_EVT, 32'h7ffff);
    gpio_in <= w[GPIO_N-1:0];
    cyc(5);
    rd(REG_GPIO_EVT);
    chk(rd_q, w & v, "rise");
    gpio_in <= '0;
    cyc(5);
    rd(REG_GPIO_EVT);
    chk(rd_q, w, "fall");
    fin("gpio");
    wr(REG_GPIO_EDG, 32'h7ffff);
    wr(REG_WAKE_EN, 32'h21);
    wr(REG_CTRL, 32'h0300);
    n_rb = 0;
    gpio_in <= 19'h8;
    cyc(6);
    chk(led, 3'h7, "asleep");
    wake_src.rtc <= 1'h1;
    cyc(6);
    chk(n_rb, 0, "rtc woke sleep");
    wake_src.rtc <= 1'h0;
    gpio_in <= '0;
    cyc(4);
    gpio_in <= 19'h8;
    cyc(6);
    chk(n_rb, 1, "pin wake");
    wr(REG_CTRL, 32'h1f20);
    cyc(4);
    wake_src.lp_comp <= 1'h1;
    cyc(4);
    wake_src.lp_comp <= 1'h0;
    chk(n_rb, 2, "comparator wake");
    wr(REG_CTRL, 32'h1f10);
    cyc(2);
    n_sc = 0;
    cyc(40);
    chk(n_sc >= 9 && n_sc <= 11, 1, "slow clock");
    chk(led, 3'h7, "standby dark");
    wake_src.rtc <= 1'h1;
    cyc(4);
    wr(REG_CTRL, 32'h1f00);
    cyc(4);
    n_sc = 0;
    cyc(20);
    chk(n_sc, 0, "awake");
    chk(led, 3'h5, "idle");
    wr(REG_CTRL, 32'h61f00);
    cyc(4);
    chk(dtr_n, 0, "bonded");
    fin("power modes");
    boot(1'h0, 1'h1);
    chk(start_action, MSP_START_SERIAL_DEFAULTS, "sw2");
    sw2_req <= 1'h0;
    cyc(6);
    chk(connect_req, 0, "no connect");
    sw2_req <= 1'h1;
    cyc(6);
    chk(connect_req, 1, "connect");
    chk(start_action, MSP_START_SERIAL_DEFAULTS, "resample");
    boot(1'h1, 1'h1);
    chk(start_action, MSP_START_BOOTLOADER, "boot");
    cyc(40);
    sw1_req <= 1'h0;
    cyc(150);
    chk(factory_reset, 0, "early release");
    boot(1'h1, 1'h1);
    cyc(120);
    chk(factory_reset, 1, "factory");
    chk(start_action, MSP_START_NORMAL, "after factory");
    fin("straps");
    boot(1'h0, 1'h0);
    n_sr = 0;
    wr(REG_CTRL, 32'h1f08);
    cyc(2);
    brownout <= 1'h1;
    cyc(4);
    brownout <= 1'h0;
    cyc(4);
    chk(nvm_save_req, 0, "save in brownout");
    chk(led, 3'h7, "lit in brownout");
    chk(n_sr, 0, "reset in brownout");
    fin("brownout");
    close_out();
  end
endmodule : test_module_status_power_control
